//--- dmatc_pkg.sv
// Package of constants and types for the DMA terminal-count and status block
package dmatc_pkg;
  localparam int unsigned NUM_CH        = 4;
  localparam int unsigned ADDR_W        = 16;
  // Register byte offsets
  localparam logic [7:0]  OFS_BUS_REQ   = 8'h00;
  localparam logic [7:0]  OFS_IMR0      = 8'h04;
  localparam logic [7:0]  OFS_IRQ_MASK  = 8'h08;
  localparam logic [7:0]  OFS_STATUS    = 8'h0c;
  localparam logic [7:0]  OFS_MIRROR    = 8'h10;
  localparam logic [7:0]  OFS_CMD       = 8'h14;
  localparam logic [7:0]  OFS_CH_BASE   = 8'h20;
  localparam logic [7:0]  OFS_CH_CNT    = 8'h04;
  localparam int unsigned CH_STRIDE_LOG = 3;
  // Field positions
  localparam int unsigned BREQ_GATE_BIT = 0;
  localparam int unsigned BREQ_INH_LSB  = 4;
  localparam int unsigned BREQ_OWN_BIT  = 8;
  localparam int unsigned IMR_GLOB_BIT  = 0;
  localparam int unsigned MASK_TC_LSB   = 0;
  localparam int unsigned MASK_REQ_LSB  = 4;
  localparam int unsigned STS_TC_LSB    = 0;
  localparam int unsigned STS_REQ_LSB   = 4;
  localparam int unsigned CMD_COPY_BIT  = 0;
  localparam int unsigned CMD_EN_LSB    = 4;
  localparam int unsigned CMD_DIR_LSB   = 8;
  localparam int unsigned CMD_SWREQ_BIT = 12;
  // Reset values
  localparam logic [3:0]  INH_RST       = 4'h0;
  localparam logic [3:0]  MASK_RST      = 4'h0;
  localparam logic [3:0]  EN_RST        = 4'h0;
  localparam logic [3:0]  DIR_RST       = 4'h0;
  localparam logic [15:0] ADDR_RST      = 16'h0000;
  localparam logic [15:0] CNT_RST       = 16'h0000;
  // Address map
  localparam int unsigned PKT_SEL_BIT   = 15;
  localparam int unsigned PKT_NUM_LSB   = 10;
  localparam int unsigned PKT_NUM_W     = 5;
  localparam int unsigned PKT_OFF_W     = 10;
  localparam logic [9:0]  PKT_HDR_BYTES = 10'h008;
  localparam int unsigned PKT_PAYLOAD   = 1016;
  // Copy channels
  localparam int unsigned COPY_SRC_CH   = 0;
  localparam int unsigned COPY_DST_CH   = 1;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_DEV  = 2'b01,
    ST_CRD  = 2'b10,
    ST_CWR  = 2'b11
  } dmatc_state_type;
endpackage : dmatc_pkg

//--- dmatc_core.sv
// DMA engine with terminal-count gating, status, mirror and address map
//
// Implementation choices: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/10ps
module dmatc_core
  import dmatc_pkg::*;
#(
  parameter int unsigned BUF_W     = 8,
  parameter int unsigned BUF_DEPTH = 2
) (
  // Clock and reset
  input  wire logic                 clock_i,
  input  wire logic                 sys_rst_i,
  // AHB-Lite slave
  input  wire logic                 hsel_i,
  input  wire logic [31:0]          haddr_i,
  input  wire logic [1:0]           htrans_i,
  input  wire logic                 hwrite_i,
  input  wire logic [2:0]           hsize_i,
  input  wire logic [31:0]          hwdata_i,
  input  wire logic                 hready_i,
  output logic      [31:0]          hrdata_o,
  output logic                      hreadyout_o,
  output logic                      hresp_o,
  // Peripheral request side
  input  wire logic [dmatc_pkg::NUM_CH-1:0] dreq_i,
  output logic      [dmatc_pkg::NUM_CH-1:0] dack_o,
  output logic      [dmatc_pkg::NUM_CH-1:0] terminal_count_o,
  // Memory side
  output logic                      mem_rd_o,
  output logic                      mem_wr_o,
  output logic                      mem_ext_sel_o,
  output logic                      mem_pkt_sel_o,
  output logic      [dmatc_pkg::PKT_NUM_W-1:0] mem_pkt_num_o,
  output logic      [dmatc_pkg::PKT_OFF_W-1:0] mem_pkt_off_o,
  output logic                      mem_hdr_o,
  output logic      [dmatc_pkg::ADDR_W-1:0]    mem_addr_o,
  output logic      [BUF_W-1:0]     mem_wdata_o,
  input  wire logic [BUF_W-1:0]     mem_rdata_i,
  input  wire logic                 mem_ready_i,
  // Status
  output logic                      dma_irq_o,
  output logic                      controller_owns_bus_flag_o
);
  import dmatc_pkg::*;

  dmatc_state_type           state_q;
  logic [1:0]                ch_q, pick, fill_q;
  logic [ADDR_W-1:0]         cur_addr, addr_q [NUM_CH], cnt_q [NUM_CH];
  logic                      hold_ack_gate_q, dma_irq_global_enable_q, copy_mode_bit_q;
  logic [NUM_CH-1:0]         channel_count_end_inhibit_q, tc_irq_en_q, req_irq_en_q;
  logic [NUM_CH-1:0]         tc_sts_q, req_sts_q, ch_en_q, dir_q;
  logic [NUM_CH-1:0]         s1_q, s2_q, s3_q, dreq_q, rearm_q, done, tc_raw, elig;
  logic                      swreq_q, wr_pend_q, wp_q, rp_q;
  logic [7:0]                wr_ofs_q, ap_ofs, sts_byte;
  logic [31:0]               hrdata_q, rd_mux;
  logic [BUF_W-1:0]          buf_q [BUF_DEPTH];
  logic                      buf_in_ready, buf_out_valid, push, pop;
  logic                      ap_valid, rd_status, step, last;

  // Bus answers without wait states, always OKAY
  assign hreadyout_o = 1'b1;
  assign hresp_o     = 1'b0;
  assign hrdata_o    = hrdata_q;
  assign ap_valid    = hsel_i & htrans_i[1] & hready_i;
  assign ap_ofs      = haddr_i[7:0];
  assign rd_status   = ap_valid & ~hwrite_i & (ap_ofs == OFS_STATUS);
  assign sts_byte    = {req_sts_q, tc_sts_q};

  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (ap_ofs)
      OFS_BUS_REQ: begin
        rd_mux[BREQ_GATE_BIT]               = hold_ack_gate_q;
        rd_mux[BREQ_INH_LSB +: NUM_CH]      = channel_count_end_inhibit_q;
        rd_mux[BREQ_OWN_BIT]                = controller_owns_bus_flag_o;
      end
      OFS_IMR0:     rd_mux[IMR_GLOB_BIT]    = dma_irq_global_enable_q;
      OFS_IRQ_MASK: rd_mux[7:0]             = {req_irq_en_q, tc_irq_en_q};
      OFS_STATUS:   rd_mux[7:0]             = sts_byte;
      OFS_MIRROR:   rd_mux[7:0]             = sts_byte;
      OFS_CMD: begin
        rd_mux[CMD_COPY_BIT]                = copy_mode_bit_q;
        rd_mux[CMD_EN_LSB +: NUM_CH]        = ch_en_q;
        rd_mux[CMD_DIR_LSB +: NUM_CH]       = dir_q;
        rd_mux[CMD_SWREQ_BIT]               = swreq_q;
      end
      default: if (ap_ofs[7:5] == OFS_CH_BASE[7:5])
        rd_mux[15:0] = ap_ofs[2] ? cnt_q[ap_ofs[4:3]] : addr_q[ap_ofs[4:3]];
    endcase
  end

  // Address phase capture and read data
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wr_pend_q <= 1'b0;
      wr_ofs_q  <= 8'h00;
      hrdata_q  <= 32'h0000_0000;
    end else begin
      wr_pend_q <= ap_valid & hwrite_i;
      if (ap_valid) wr_ofs_q <= ap_ofs;
      if (ap_valid & ~hwrite_i) hrdata_q <= rd_mux;
    end
  end

  // Control registers written by software
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      hold_ack_gate_q             <= 1'b0;
      channel_count_end_inhibit_q <= INH_RST;
      dma_irq_global_enable_q     <= 1'b0;
      tc_irq_en_q                 <= MASK_RST;
      req_irq_en_q                <= MASK_RST;
      copy_mode_bit_q             <= 1'b0;
      dir_q                       <= DIR_RST;
    end else if (wr_pend_q) begin
      unique case (wr_ofs_q)
        OFS_BUS_REQ: begin
          hold_ack_gate_q             <= hwdata_i[BREQ_GATE_BIT];
          channel_count_end_inhibit_q <= hwdata_i[BREQ_INH_LSB +: NUM_CH];
        end
        OFS_IMR0: dma_irq_global_enable_q <= hwdata_i[IMR_GLOB_BIT];
        OFS_IRQ_MASK: begin
          tc_irq_en_q  <= hwdata_i[MASK_TC_LSB +: NUM_CH];
          req_irq_en_q <= hwdata_i[MASK_REQ_LSB +: NUM_CH];
        end
        OFS_CMD: begin
          copy_mode_bit_q <= hwdata_i[CMD_COPY_BIT];
          dir_q           <= hwdata_i[CMD_DIR_LSB +: NUM_CH];
        end
        default: ;
      endcase
    end
  end

  // Enables and software request; hardware clears them at session end
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ch_en_q <= EN_RST;
      swreq_q <= 1'b0;
    end else begin
      if (wr_pend_q && wr_ofs_q == OFS_CMD) begin
        ch_en_q <= hwdata_i[CMD_EN_LSB +: NUM_CH] & ~done;
        swreq_q <= hwdata_i[CMD_SWREQ_BIT] & ~done[COPY_DST_CH];
      end else begin
        ch_en_q <= ch_en_q & ~done;
        if (done[COPY_DST_CH]) swreq_q <= 1'b0;
      end
    end
  end

  // Request pins: three stages, a change counts when the last two agree
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      s1_q   <= '0;
      s2_q   <= '0;
      s3_q   <= '0;
      dreq_q <= '0;
    end else begin
      s1_q   <= dreq_i;
      s2_q   <= s1_q;
      s3_q   <= s2_q;
      dreq_q <= (s2_q & s3_q) | (dreq_q & (s2_q | s3_q));
    end
  end

  // Status bits: set wins over clear on read; mirror shares these flops
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tc_sts_q  <= '0;
      req_sts_q <= '0;
    end else begin
      tc_sts_q  <= (rd_status ? '0 : tc_sts_q) | done;
      req_sts_q <= (rd_status ? '0 : req_sts_q) | (dreq_q & ~rearm_q);
    end
  end

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) dma_irq_o <= 1'b0;
    else dma_irq_o <= dma_irq_global_enable_q &
                      |((tc_sts_q & tc_irq_en_q) | (req_sts_q & req_irq_en_q));
  end

  // Channel selection: lowest eligible channel first
  always_comb begin
    elig = dreq_q & ch_en_q & ~rearm_q;
    if (copy_mode_bit_q) elig[1:0] = 2'b00;
    pick = 2'd0;
    for (int i = NUM_CH - 1; i >= 0; i--) begin
      if (elig[i]) pick = i[1:0];
    end
  end

  // Two-entry holding buffer for copies
  assign buf_in_ready  = (fill_q != 2'd2);
  assign buf_out_valid = (fill_q != 2'd0);
  assign push          = (state_q == ST_CRD) & mem_ready_i & buf_in_ready;
  assign pop           = (state_q == ST_CWR) & mem_ready_i & buf_out_valid;

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wp_q   <= 1'b0;
      rp_q   <= 1'b0;
      fill_q <= 2'd0;
      for (int i = 0; i < BUF_DEPTH; i++) buf_q[i] <= '0;
    end else begin
      if (push) begin
        buf_q[wp_q] <= mem_rdata_i;
        wp_q        <= ~wp_q;
      end
      if (pop) rp_q <= ~rp_q;
      fill_q <= fill_q + {1'b0, push} - {1'b0, pop};
    end
  end

  // Memory cycle and address map
  always_comb begin
    mem_rd_o = 1'b0;
    mem_wr_o = 1'b0;
    dack_o   = '0;
    cur_addr = addr_q[ch_q];
    unique case (state_q)
      ST_IDLE: ;
      ST_DEV: begin
        dack_o[ch_q] = 1'b1;
        mem_wr_o     = dir_q[ch_q];
        mem_rd_o     = ~dir_q[ch_q];
      end
      ST_CRD: begin
        cur_addr = addr_q[COPY_SRC_CH];
        mem_rd_o = buf_in_ready;
      end
      ST_CWR: begin
        cur_addr = addr_q[COPY_DST_CH];
        mem_wr_o = buf_out_valid;
      end
    endcase
  end

  assign mem_addr_o    = cur_addr;
  assign mem_wdata_o   = buf_q[rp_q];
  assign mem_ext_sel_o = ~cur_addr[PKT_SEL_BIT];
  assign mem_pkt_sel_o = cur_addr[PKT_SEL_BIT];
  assign mem_pkt_num_o = cur_addr[PKT_NUM_LSB +: PKT_NUM_W];
  assign mem_pkt_off_o = cur_addr[PKT_OFF_W-1:0];
  assign mem_hdr_o     = cur_addr[PKT_SEL_BIT] &
                         (cur_addr[PKT_OFF_W-1:0] < PKT_HDR_BYTES);

  // Last transfer of a session and its completion
  assign step = ((state_q == ST_DEV) & mem_ready_i) | pop;
  assign last = (cnt_q[ch_q] == CNT_RST);
  always_comb begin
    tc_raw = '0;
    if (state_q == ST_DEV || state_q == ST_CWR) tc_raw[ch_q] = last;
    done = '0;
    if (step) done[ch_q] = last;
  end
  assign terminal_count_o = tc_raw & ~channel_count_end_inhibit_q;

  // Engine sequencing
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_q <= ST_IDLE;
      ch_q    <= 2'd0;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (hold_ack_gate_q) begin
            if (copy_mode_bit_q && swreq_q) begin
              state_q <= ST_CRD;
              ch_q    <= COPY_DST_CH[1:0];
            end else if (|elig) begin
              state_q <= ST_DEV;
              ch_q    <= pick;
            end
          end
        end
        ST_DEV: if (mem_ready_i) state_q <= ST_IDLE;
        ST_CRD: if (push) state_q <= ST_CWR;
        ST_CWR: if (pop) state_q <= last ? ST_IDLE : ST_CRD;
      endcase
    end
  end

  // Re-arm waits for the request to fall after each serviced byte
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) rearm_q <= '0;
    else begin
      rearm_q <= rearm_q & dreq_q;
      if (state_q == ST_DEV && mem_ready_i) rearm_q[ch_q] <= 1'b1;
    end
  end

  // Bus owned while gated or inside a transfer
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) controller_owns_bus_flag_o <= 1'b0;
    else controller_owns_bus_flag_o <= hold_ack_gate_q | (state_q != ST_IDLE) & ~
                                       ((state_q == ST_DEV & mem_ready_i) |
                                        (pop & last));
  end

  // Address and count registers
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < NUM_CH; i++) begin
        addr_q[i] <= ADDR_RST;
        cnt_q[i]  <= CNT_RST;
      end
    end else begin
      if (step) begin
        cnt_q[ch_q] <= cnt_q[ch_q] - 16'h0001;
        if (state_q == ST_DEV) addr_q[ch_q] <= addr_q[ch_q] + 16'h0001;
        else addr_q[COPY_DST_CH] <= addr_q[COPY_DST_CH] + 16'h0001;
      end
      if (push) addr_q[COPY_SRC_CH] <= addr_q[COPY_SRC_CH] + 16'h0001;
      if (wr_pend_q && wr_ofs_q[7:5] == OFS_CH_BASE[7:5]) begin
        if (wr_ofs_q[2]) cnt_q[wr_ofs_q[4:3]] <= hwdata_i[15:0];
        else addr_q[wr_ofs_q[4:3]] <= hwdata_i[15:0];
      end
    end
  end
endmodule : dmatc_core

//--- dmatc_assertions.sv
// Checker for the DMA terminal-count block ports
`timescale 1ns/10ps
module dmatc_assertions #(
  parameter int unsigned BUF_W = 8
) (
  // Clock and reset
  input wire logic                             clock_i,
  input wire logic                             sys_rst_i,
  // Register bus
  input wire logic                             hsel_i,
  input wire logic [31:0]                      haddr_i,
  input wire logic [1:0]                       htrans_i,
  input wire logic                             hwrite_i,
  input wire logic [31:0]                      hwdata_i,
  input wire logic                             hready_i,
  // Peripheral and memory side
  input wire logic [dmatc_pkg::NUM_CH-1:0]     dack_o,
  input wire logic [dmatc_pkg::NUM_CH-1:0]     terminal_count_o,
  input wire logic                             mem_rd_o,
  input wire logic                             mem_wr_o,
  input wire logic                             mem_ext_sel_o,
  input wire logic                             mem_pkt_sel_o,
  input wire logic [dmatc_pkg::PKT_NUM_W-1:0]  mem_pkt_num_o,
  input wire logic [dmatc_pkg::PKT_OFF_W-1:0]  mem_pkt_off_o,
  input wire logic                             mem_hdr_o,
  input wire logic [dmatc_pkg::ADDR_W-1:0]     mem_addr_o,
  input wire logic [BUF_W-1:0]                 mem_wdata_o,
  input wire logic                             mem_ready_i,
  // Status
  input wire logic                             dma_irq_o,
  input wire logic                             controller_owns_bus_flag_o
);
  import dmatc_pkg::*;
  default clocking @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);
  logic       ap_wr_q;
  logic [7:0] ap_a_q;
  logic       gate_q;
  logic       glob_q;
  logic [3:0] inh_q;
  logic       strb;
  assign strb = mem_rd_o | mem_wr_o;
  // Address phase capture
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ap_wr_q <= 1'b0;
      ap_a_q  <= 8'h00;
    end else if (hready_i) begin
      ap_wr_q <= hsel_i & htrans_i[1] & hwrite_i;
      ap_a_q  <= haddr_i[7:0];
    end
  end
  // Shadow of written control bits
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      gate_q <= 1'b0;
      inh_q  <= 4'h0;
      glob_q <= 1'b0;
    end else if (ap_wr_q && hready_i) begin
      if (ap_a_q == OFS_BUS_REQ) begin
        gate_q <= hwdata_i[BREQ_GATE_BIT];
        inh_q  <= hwdata_i[BREQ_INH_LSB+:4];
      end
      if (ap_a_q == OFS_IMR0) begin
        glob_q <= hwdata_i[IMR_GLOB_BIT];
      end
    end
  end
  tc_in_xfer_a: assert property (|terminal_count_o |-> strb)
    else $error("terminal count outside a transfer");
  tc_gated_a: assert property ((terminal_count_o & inh_q) == 4'h0)
    else $error("terminal count seen on an inhibited channel");
  irq_global_a: assert property (dma_irq_o |-> glob_q || $past(glob_q))
    else $error("interrupt raised without global enable");
  rd_wr_excl_a: assert property (!(mem_rd_o && mem_wr_o))
    else $error("read and write strobes together");
  rd_hold_a: assert property (mem_rd_o && !mem_ready_i |=> mem_rd_o && $stable(mem_addr_o))
    else $error("read cycle dropped before ready");
  wr_hold_a: assert property (mem_wr_o && !mem_ready_i |=> mem_wr_o && $stable(mem_wdata_o))
    else $error("write data changed before ready");
  ext_map_a: assert property (strb |-> mem_ext_sel_o == !mem_addr_o[15])
    else $error("external select wrong");
  pkt_map_a: assert property (strb && mem_addr_o[15] |-> mem_pkt_sel_o
    && mem_pkt_num_o == mem_addr_o[14:10] && mem_pkt_off_o == mem_addr_o[9:0])
    else $error("packet window decode wrong");
  hdr_flag_a: assert property (strb && mem_pkt_sel_o |-> mem_hdr_o == (mem_pkt_off_o < 10'h008))
    else $error("header flag wrong");
  owns_drop_a: assert property ((!gate_q && !strb) [*2] |-> ##[0:2] !controller_owns_bus_flag_o)
    else $error("bus not released after gate clear");
  cover property (|terminal_count_o);
  cover property (mem_wr_o && mem_ready_i && mem_pkt_sel_o);
  cover property ($rose(dma_irq_o));
endmodule : dmatc_assertions

bind dmatc_core dmatc_assertions #(.BUF_W(BUF_W)) u_dmatc_assertions (
  .clock_i(clock_i), .sys_rst_i(sys_rst_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
  .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hwdata_i(hwdata_i), .hready_i(hready_i),
  .dack_o(dack_o), .terminal_count_o(terminal_count_o), .mem_rd_o(mem_rd_o),
  .mem_wr_o(mem_wr_o), .mem_ext_sel_o(mem_ext_sel_o), .mem_pkt_sel_o(mem_pkt_sel_o),
  .mem_pkt_num_o(mem_pkt_num_o), .mem_pkt_off_o(mem_pkt_off_o), .mem_hdr_o(mem_hdr_o),
  .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o), .mem_ready_i(mem_ready_i),
  .dma_irq_o(dma_irq_o), .controller_owns_bus_flag_o(controller_owns_bus_flag_o));

//--- dmatc_far_model.sv
// Peripheral and memory model on the far side of the DMA block
`timescale 1ns/10ps
module dmatc_far_model (
  // Clock, reset and bench control
  input  wire logic                         clock_i,
  input  wire logic                         sys_rst_i,
  input  wire logic [dmatc_pkg::NUM_CH-1:0] want_i,
  input  wire logic [2:0]                   slow_i,
  // Block side
  input  wire logic [dmatc_pkg::NUM_CH-1:0] dack_i,
  input  wire logic [dmatc_pkg::NUM_CH-1:0] tc_i,
  input  wire logic                         mem_rd_i,
  input  wire logic                         mem_wr_i,
  input  wire logic [dmatc_pkg::ADDR_W-1:0] mem_addr_i,
  input  wire logic [7:0]                   mem_wdata_i,
  output logic      [dmatc_pkg::NUM_CH-1:0] dreq_o,
  output logic      [7:0]                   mem_rdata_o,
  output logic                              mem_ready_o
);
  import dmatc_pkg::*;
  logic [7:0]  mem [0:65535];
  logic [2:0]  wait_q;
  logic [2:0]  gap_q [NUM_CH];
  int          tc_n [NUM_CH];
  int          wr_n;
  logic [15:0] last_wr;
  always @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      dreq_o      <= '0;
      mem_ready_o <= 1'b0;
      mem_rdata_o <= 8'h00;
      wait_q      <= 3'h0;
      wr_n        <= 0;
      for (int c = 0; c < NUM_CH; c++) begin
        gap_q[c] <= 3'h0;
        tc_n[c]  <= 0;
      end
    end else begin
      // Memory answers after slow_i wait cycles; idle data toggles
      if (!(mem_rd_i || mem_wr_i) || mem_ready_o) begin
        mem_ready_o <= 1'b0;
        wait_q      <= 3'h0;
        mem_rdata_o <= ~mem_rdata_o;
      end else if (wait_q >= slow_i) begin
        mem_ready_o <= 1'b1;
        mem_rdata_o <= mem_rd_i ? mem[mem_addr_i] : ~mem_rdata_o;
      end else begin
        wait_q      <= wait_q + 3'h1;
        mem_rdata_o <= ~mem_rdata_o;
      end
      if (mem_ready_o && mem_wr_i) begin
        mem[mem_addr_i] <= mem_wdata_i;
        wr_n            <= wr_n + 1;
        last_wr         <= mem_addr_i;
      end
      // Peripheral drops request on acknowledge, re-asks after a gap
      for (int c = 0; c < NUM_CH; c++) begin
        if (mem_ready_o && tc_i[c]) begin
          tc_n[c] <= tc_n[c] + 1;
        end
        if (dack_i[c]) begin
          dreq_o[c] <= 1'b0;
          gap_q[c]  <= 3'h5;
        end else if (gap_q[c] != 3'h0) begin
          gap_q[c] <= gap_q[c] - 3'h1;
        end else begin
          dreq_o[c] <= want_i[c];
        end
      end
    end
  end
endmodule : dmatc_far_model

//--- tb_top.sv
// Testbench for the DMA terminal-count block
`timescale 1ns/10ps
module tb_top;
  import dmatc_pkg::*;
  logic        clock_i = 1'b0;
  logic        sys_rst_i = 1'b0;
  logic        hsel_i = 1'b0;
  logic [31:0] haddr_i = 32'h0;
  logic [1:0]  htrans_i = 2'b00;
  logic        hwrite_i = 1'b0;
  logic [2:0]  hsize_i = 3'h2;
  logic [31:0] hwdata_i = 32'h0;
  logic [31:0] hrdata_o;
  logic        hreadyout_o;
  logic        hresp_o;
  logic [3:0]  dreq_i, dack_o, terminal_count_o, want_q = 4'h0;
  logic        mem_rd_o, mem_wr_o, mem_ext_sel_o, mem_pkt_sel_o, mem_hdr_o, mem_ready_i;
  logic [4:0]  mem_pkt_num_o;
  logic [9:0]  mem_pkt_off_o;
  logic [15:0] mem_addr_o;
  logic [7:0]  mem_wdata_o, mem_rdata_i;
  logic        dma_irq_o, controller_owns_bus_flag_o;
  logic [2:0]  slow_q = 3'h0;
  logic [31:0] rv;
  int          mismatches = 0;
  int          n_tests = 0;
  always #2 clock_i = ~clock_i;
  dmatc_core u_dmatc_core (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .hsel_i(hsel_i),
    .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i),
    .hwdata_i(hwdata_i), .hready_i(hreadyout_o), .hrdata_o(hrdata_o),
    .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .dreq_i(dreq_i), .dack_o(dack_o),
    .terminal_count_o(terminal_count_o), .mem_rd_o(mem_rd_o), .mem_wr_o(mem_wr_o),
    .mem_ext_sel_o(mem_ext_sel_o), .mem_pkt_sel_o(mem_pkt_sel_o),
    .mem_pkt_num_o(mem_pkt_num_o), .mem_pkt_off_o(mem_pkt_off_o), .mem_hdr_o(mem_hdr_o),
    .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o), .mem_rdata_i(mem_rdata_i),
    .mem_ready_i(mem_ready_i), .dma_irq_o(dma_irq_o),
    .controller_owns_bus_flag_o(controller_owns_bus_flag_o));
  dmatc_far_model u_dmatc_far_model (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
    .want_i(want_q), .slow_i(slow_q), .dack_i(dack_o), .tc_i(terminal_count_o),
    .mem_rd_i(mem_rd_o), .mem_wr_i(mem_wr_o), .mem_addr_i(mem_addr_o),
    .mem_wdata_i(mem_wdata_o), .dreq_o(dreq_i), .mem_rdata_o(mem_rdata_i),
    .mem_ready_o(mem_ready_i));
  task automatic give_verdict();
    if (mismatches == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : give_verdict
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel_i <= 1'b1;
    htrans_i <= 2'b10;
    hwrite_i <= wr;
    haddr_i <= {24'h0, a};
    do @(posedge clock_i);
    while (hreadyout_o !== 1'b1);
    hsel_i <= 1'b0;
    htrans_i <= 2'b00;
    hwdata_i <= wd;
    do @(posedge clock_i);
    while (hreadyout_o !== 1'b1);
    rv = hrdata_o;
  endtask : ahb
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                     input string nm);
    ahb(1'b0, a, 32'h0);
    chk(nm, rv & m, e);
  endtask : rdc
  task automatic wait_done(input int b);
    do ahb(1'b0, OFS_MIRROR, 32'h0);
    while (rv[b] !== 1'b1);
  endtask : wait_done
  task automatic dev_run(input logic [15:0] addr);
    ahb(1'b1, OFS_CH_BASE + 8'h10, {16'h0, addr});
    ahb(1'b1, OFS_CH_BASE + OFS_CH_CNT + 8'h10, 32'h1);
    ahb(1'b0, OFS_STATUS, 32'h0);
    ahb(1'b1, OFS_CMD, 32'h0440);
    want_q <= 4'h4;
    wait_done(2);
    want_q <= 4'h0;
  endtask : dev_run
  initial begin
    sys_rst_i <= 1'b1;
    repeat (4) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    rdc(OFS_BUS_REQ, '1, 32'h0, "bus_req reset");
    ahb(1'b1, 8'h18, '1);
    rdc(8'h18, '1, 32'h0, "unmapped");
    ahb(1'b1, OFS_BUS_REQ, 32'h1);
    ahb(1'b0, OFS_BUS_REQ, 32'h0);
    rdc(OFS_BUS_REQ, '1, 32'h101, "owns flag");
    ahb(1'b1, OFS_IRQ_MASK, 32'hf);
    dev_run(16'h8008);
    chk("tc pin", u_dmatc_far_model.tc_n[2], 1);
    chk("bytes", u_dmatc_far_model.wr_n, 2);
    chk("last addr", u_dmatc_far_model.last_wr, 16'h8009);
    chk("irq off", dma_irq_o, 0);
    ahb(1'b1, OFS_IMR0, 32'h1);
    rdc(OFS_IMR0, '1, 32'h1, "imr0");
    chk("irq on", dma_irq_o, 1);
    rdc(OFS_MIRROR, 32'hf, 32'h4, "mirror");
    rdc(OFS_MIRROR, 32'hf, 32'h4, "mirror again");
    rdc(OFS_STATUS, 32'hf, 32'h4, "status");
    rdc(OFS_MIRROR, 32'hf, 32'h0, "mirror cleared");
    rdc(OFS_STATUS, 32'hf, 32'h0, "status cleared");
    chk("irq cleared", dma_irq_o, 0);
    ahb(1'b1, OFS_IRQ_MASK, 32'h0);
    ahb(1'b1, OFS_BUS_REQ, 32'h41);
    slow_q <= 3'h3;
    dev_run(16'h0010);
    chk("tc inhibited", u_dmatc_far_model.tc_n[2], 1);
    chk("ext addr", u_dmatc_far_model.last_wr, 16'h0011);
    chk("irq masked", dma_irq_o, 0);
    want_q <= 4'h8;
    ahb(1'b1, OFS_IRQ_MASK, 32'h4);
    rdc(OFS_MIRROR, 32'hf, 32'h4, "done inhibited");
    chk("irq source", dma_irq_o, 1);
    ahb(1'b1, OFS_IMR0, 32'h0);
    rdc(OFS_STATUS, 32'hf, 32'h4, "status inhibited");
    chk("irq global off", dma_irq_o, 0);
    ahb(1'b1, OFS_IRQ_MASK, 32'h80);
    ahb(1'b1, OFS_IMR0, 32'h1);
    rdc(OFS_MIRROR, 32'hf0, 32'h80, "request seen");
    chk("irq request", dma_irq_o, 1);
    want_q <= 4'h0;
    ahb(1'b1, OFS_BUS_REQ, 32'h1);
    u_dmatc_far_model.mem[16'h0100] = 8'ha5;
    u_dmatc_far_model.mem[16'h0101] = 8'h3c;
    ahb(1'b1, OFS_CH_BASE, 32'h0100);
    ahb(1'b1, OFS_CH_BASE + 8'h08, 32'h8406);
    ahb(1'b1, OFS_CH_BASE + 8'h0c, 32'h1);
    ahb(1'b1, OFS_CMD, 32'h1001);
    wait_done(1);
    chk("copy 0", u_dmatc_far_model.mem[16'h8406], 8'ha5);
    chk("copy 1", u_dmatc_far_model.mem[16'h8407], 8'h3c);
    chk("copy tc", u_dmatc_far_model.tc_n[1], 1);
    ahb(1'b1, OFS_CMD, 32'h0);
    ahb(1'b1, OFS_BUS_REQ, 32'h0);
    ahb(1'b0, OFS_BUS_REQ, 32'h0);
    rdc(OFS_BUS_REQ, '1, 32'h0, "bus released");
    chk("owns pin", controller_owns_bus_flag_o, 0);
    give_verdict();
  end
  initial begin
    repeat (20000) @(posedge clock_i);
    mismatches++;
    give_verdict();
  end
endmodule : tb_top
